// File: design/uptg_top.sv
/*
 * Serial transceiver with receive holding, overrun, parity and multidrop,
 * transmit guard time and a receiver idle time-out counted in bit periods.
 * Assumes a plain strobe register port and an idle-high serial line.
 */
//
// Behaviour
// - Finished character goes to receive holding register and sets receive ready.
// - Character finishing while ready still set sets overrun and overwrites held byte.
// - Overrun clears only on a control write with clear status bit at one.
// - Parity type field picks five parity modes; two further codes pick multidrop.
// - Even parity sends zero for even ones count; receiver flags mismatch.
// - Odd parity sends one for even ones count; receiver flags mismatch.
// - Mark parity always sends one; parity bit received at zero is an error.
// - Space parity always sends zero; parity bit received at one is an error.
// - No parity sends no parity bit and never reports a parity error.
// - Detected parity error sets parity flag; clear status command clears it.
// - Codes 0x6 and 0x07 select multidrop: data parity zero, address parity one.
// - In multidrop a received high parity bit sets the parity error flag.
// - After send address command the next written byte goes out with parity one.
// - Nonzero guard length holds line high that many bit periods after stop.
// - Transmit ready rises only at next start bit while a byte waits in guard.
// - Transmit empty stays low until the guard period has completed.
// - Idle limit zero disables time-out and stops the time-out flag from rising.
// - Sixteen-bit counter loads limit, counts bit periods, reloads per character.
// - A rising time-out flag can raise an interrupt request to software.
// - Arm command stops the counter until the first new character arrives.
// - Reload command restarts the count at once from the programmed limit.
// - Transmit ready shows holding register empty; empty shows all bytes sent.
`timescale 1ns/1ps
module uptg_top
	import uptg_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// Register port
	input  wire logic [4:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Serial line
	input  wire logic        rxd_in,
	output logic             txd_out,
	// Time-out event
	output logic             timeout_event
);
	// ****************************************************************
	// Types and decode functions
	// ****************************************************************
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uptg_rx_type;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GUARD} uptg_tx_type;

	function automatic logic par_used(input logic [2:0] mode);
		par_used = (mode != UPTG_PAR_NONE) && (mode != UPTG_PAR_NONE2);
	endfunction

	function automatic logic par_gen(input logic [2:0] mode, input logic [7:0] d, input logic addr);
		unique case (mode)
			UPTG_PAR_EVEN:  par_gen = ^d;
			UPTG_PAR_ODD:   par_gen = ~^d;
			UPTG_PAR_SPACE: par_gen = 1'b0;
			UPTG_PAR_MARK:  par_gen = 1'b1;
			UPTG_PAR_MD_A:  par_gen = addr;
			UPTG_PAR_MD_B:  par_gen = addr;
			default:        par_gen = 1'b0;
		endcase
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic        samp_en;
	logic        bit_en;
	logic        rxd_s;
	logic [2:0]  mode_q;
	logic [7:0]  guard_q;
	logic [15:0] idle_limit_q;
	logic [15:0] baud_q;
	logic [31:0] rd_mux;
	logic        wr_ctrl;
	logic        wr_thr;
	logic        rd_rhr;
	logic        cmd_clear;
	logic        cmd_arm;
	logic        cmd_reload;
	uptg_rx_type rx_st_q;
	logic [3:0]  rx_cnt_q;
	logic [2:0]  rx_bit_q;
	logic [7:0]  rx_sh_q;
	logic        rx_par_q;
	logic        rx_tick;
	logic        rx_done;
	logic        rx_perr;
	logic [7:0]  rx_hold_q;
	logic        rx_rdy_q;
	logic        ovr_q;
	logic        perr_q;
	uptg_tx_type tx_st_q;
	logic [7:0]  thr_q;
	logic        thr_addr_q;
	logic        thr_full_q;
	logic        addr_pend_q;
	logic [7:0]  tx_sh_q;
	logic        tx_par_q;
	logic [2:0]  tx_bit_q;
	logic [7:0]  guard_cnt_q;
	logic        tx_end;
	logic        tx_load;
	logic        tx_rdy;
	logic        tx_empty;
	logic        txd_d;
	logic [15:0] to_cnt_q;
	logic        to_run_q;
	logic        to_flag_q;
	logic        to_hit;

	// ****************************************************************
	// Rate divider and line synchroniser
	// ****************************************************************
	uptg_baud_div u_div (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.divisor (baud_q),
		.samp_en (samp_en),
		.bit_en  (bit_en)
	);

	uptg_sync u_sync (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.pin_in    (rxd_in),
		.level_out (rxd_s)
	);

	// ****************************************************************
	// Register decode
	// ****************************************************************
	assign wr_ctrl    = reg_wr && (reg_addr == UPTG_ADDR_CTRL);
	assign wr_thr     = reg_wr && (reg_addr == UPTG_ADDR_TXHOLD);
	assign rd_rhr     = reg_rd && (reg_addr == UPTG_ADDR_RXHOLD);
	assign cmd_clear  = wr_ctrl && reg_wdata[UPTG_CMD_CLEAR_STATUS];
	assign cmd_arm    = wr_ctrl && reg_wdata[UPTG_CMD_ARM_IDLE];
	assign cmd_reload = wr_ctrl && reg_wdata[UPTG_CMD_RELOAD_IDLE];
	assign tx_rdy     = !thr_full_q;
	assign tx_empty   = !thr_full_q && (tx_st_q == TX_IDLE);

	assign rd_mux = (reg_addr == UPTG_ADDR_MODE)   ? {29'h0, mode_q} :
	                (reg_addr == UPTG_ADDR_STATUS) ? (32'(rx_rdy_q) << UPTG_ST_RX_READY) |
	                                                 (32'(tx_rdy) << UPTG_ST_TX_READY) |
	                                                 (32'(ovr_q) << UPTG_ST_OVERRUN) |
	                                                 (32'(perr_q) << UPTG_ST_PARITY) |
	                                                 (32'(to_flag_q) << UPTG_ST_TIMEOUT) |
	                                                 (32'(tx_empty) << UPTG_ST_TX_EMPTY) :
	                (reg_addr == UPTG_ADDR_RXHOLD) ? {24'h0, rx_hold_q} :
	                (reg_addr == UPTG_ADDR_GUARD)  ? {24'h0, guard_q} :
	                (reg_addr == UPTG_ADDR_IDLE)   ? {16'h0, idle_limit_q} :
	                (reg_addr == UPTG_ADDR_BAUD)   ? {16'h0, baud_q} : 32'h0;

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			mode_q       <= UPTG_MODE_RST;
			guard_q      <= 8'h00;
			idle_limit_q <= 16'h0000;
			baud_q       <= UPTG_BAUD_RST;
			reg_rdata    <= 32'h0;
		end
		else
		begin
			if (reg_wr && (reg_addr == UPTG_ADDR_MODE))
				mode_q <= reg_wdata[2:0];
			if (reg_wr && (reg_addr == UPTG_ADDR_GUARD))
				guard_q <= reg_wdata[7:0];
			if (reg_wr && (reg_addr == UPTG_ADDR_IDLE))
				idle_limit_q <= reg_wdata[15:0];
			if (reg_wr && (reg_addr == UPTG_ADDR_BAUD))
				baud_q <= reg_wdata[15:0];
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
		end
	end

	// ****************************************************************
	// Receiver
	// ****************************************************************
	assign rx_tick = samp_en && (rx_cnt_q == UPTG_SAMP_LAST);
	assign rx_done = rx_tick && (rx_st_q == RX_STOP);
	assign rx_perr = par_used(mode_q) && (rx_par_q != par_gen(mode_q, rx_sh_q, 1'b0));

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			rx_st_q  <= RX_IDLE;
			rx_cnt_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q  <= 8'h00;
			rx_par_q <= 1'b0;
		end
		else if (samp_en)
		begin
			rx_cnt_q <= rx_cnt_q + 4'h1;
			unique case (rx_st_q)
				RX_IDLE:
				begin
					rx_cnt_q <= 4'h0;
					if (!rxd_s)
						rx_st_q <= RX_START;
				end
				RX_START:
					if (rxd_s)
						rx_st_q <= RX_IDLE;
					else if (rx_cnt_q == UPTG_SAMP_MID)
					begin
						rx_st_q  <= RX_DATA;
						rx_cnt_q <= 4'h0;
						rx_bit_q <= 3'h0;
					end
				RX_DATA:
					if (rx_tick)
					begin
						rx_sh_q  <= {rxd_s, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == UPTG_BIT_LAST)
							rx_st_q <= par_used(mode_q) ? RX_PAR : RX_STOP;
					end
				RX_PAR:
					if (rx_tick)
					begin
						rx_par_q <= rxd_s;
						rx_st_q  <= RX_STOP;
					end
				RX_STOP:
					if (rx_tick)
						rx_st_q <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			rx_hold_q <= 8'h00;
			rx_rdy_q  <= 1'b0;
			ovr_q     <= 1'b0;
			perr_q    <= 1'b0;
		end
		else
		begin
			if (rx_done)
				rx_hold_q <= rx_sh_q;
			rx_rdy_q <= rx_done || (rx_rdy_q && !rd_rhr);
			ovr_q <= (rx_done && rx_rdy_q) || (ovr_q && !cmd_clear);
			perr_q <= (rx_done && rx_perr) || (perr_q && !cmd_clear);
		end
	end

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	// guard after stop
	assign tx_end  = bit_en && (((tx_st_q == TX_STOP) && (guard_q == 8'h00)) ||
	                            ((tx_st_q == TX_GUARD) && (guard_cnt_q == guard_q)));
	assign tx_load = thr_full_q && (((tx_st_q == TX_IDLE) && bit_en) || tx_end);
	assign txd_d   = (tx_st_q == TX_START) ? 1'b0 :
	                 (tx_st_q == TX_DATA)  ? tx_sh_q[0] :
	                 (tx_st_q == TX_PAR)   ? tx_par_q : 1'b1;

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			thr_q       <= 8'h00;
			thr_addr_q  <= 1'b0;
			thr_full_q  <= 1'b0;
			addr_pend_q <= 1'b0;
		end
		else
		begin
			if (wr_thr && !thr_full_q)
			begin
				thr_q      <= reg_wdata[7:0];
				thr_addr_q <= addr_pend_q;
			end
			if (wr_ctrl && reg_wdata[UPTG_CMD_SEND_ADDRESS])
				addr_pend_q <= 1'b1;
			else if (wr_thr && !thr_full_q)
				addr_pend_q <= 1'b0;
			thr_full_q <= (wr_thr && !thr_full_q) || (thr_full_q && !tx_load);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			tx_st_q     <= TX_IDLE;
			tx_sh_q     <= 8'h00;
			tx_par_q    <= 1'b0;
			tx_bit_q    <= 3'h0;
			guard_cnt_q <= 8'h00;
			txd_out     <= 1'b1;
		end
		else
		begin
			txd_out <= txd_d;
			if (tx_load)
			begin
				tx_st_q  <= TX_START;
				tx_sh_q  <= thr_q;
				tx_bit_q <= 3'h0;
				tx_par_q <= par_gen(mode_q, thr_q, thr_addr_q);
			end
			else if (tx_end)
				tx_st_q <= TX_IDLE;
			else if (bit_en)
			begin
				unique case (tx_st_q)
					TX_IDLE: tx_st_q <= TX_IDLE;
					TX_START: tx_st_q <= TX_DATA;
					TX_DATA:
					begin
						tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
						tx_bit_q <= tx_bit_q + 3'h1;
						if (tx_bit_q == UPTG_BIT_LAST)
							tx_st_q <= par_used(mode_q) ? TX_PAR : TX_STOP;
					end
					TX_PAR: tx_st_q <= TX_STOP;
					TX_STOP:
					begin
						tx_st_q     <= TX_GUARD;
						guard_cnt_q <= 8'h01;
					end
					TX_GUARD: guard_cnt_q <= guard_cnt_q + 8'h01;
				endcase
			end
		end
	end

	// ****************************************************************
	// Receiver idle time-out
	// ****************************************************************
	assign to_hit        = to_run_q && bit_en && (to_cnt_q == 16'h0001) && (idle_limit_q != 16'h0000);
	assign timeout_event = to_hit && !to_flag_q;

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			to_cnt_q  <= 16'h0000;
			to_run_q  <= 1'b0;
			to_flag_q <= 1'b0;
		end
		else
		begin
			if (cmd_reload || rx_done)
			begin
				to_cnt_q <= idle_limit_q;
				to_run_q <= (idle_limit_q != 16'h0000);
			end
			else if (cmd_arm)
				to_run_q <= 1'b0;
			else if (to_run_q && bit_en)
			begin
				to_cnt_q <= to_cnt_q - 16'h0001;
				to_run_q <= (to_cnt_q > 16'h0001);
			end
			to_flag_q <= to_hit || (to_flag_q && !(cmd_arm || cmd_reload));
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_start_bit;
		(tx_st_q == TX_START) ##1 !txd_out;
	endsequence

	rx_ready_set_a: assert property (@(posedge clk_sys) disable iff (!nrst) rx_done |=> rx_rdy_q)
		else $error("receive ready not set after character");
	overrun_set_a: assert property (@(posedge clk_sys) disable iff (!nrst) rx_done && rx_rdy_q |=> ovr_q)
		else $error("overrun not set");
	overrun_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst) $fell(ovr_q) |-> $past(cmd_clear))
		else $error("overrun cleared without clear status");
	mark_parity_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(tx_st_q == TX_PAR) && (mode_q == UPTG_PAR_MARK) && $stable(mode_q) |=> txd_out)
		else $error("mark parity bit not high");
	no_parity_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		rx_done && !par_used(mode_q) && !perr_q && !cmd_clear |=> !perr_q)
		else $error("parity error raised without parity");
	tx_ready_rise_a: assert property (@(posedge clk_sys) disable iff (!nrst) $rose(tx_rdy) |-> $past(tx_load))
		else $error("transmit ready rose before start bit");
	start_bit_a: assert property (@(posedge clk_sys) disable iff (!nrst) tx_load |=> s_start_bit)
		else $error("start bit not driven after load");
	guard_empty_a: assert property (@(posedge clk_sys) disable iff (!nrst) (tx_st_q == TX_GUARD) |-> !tx_empty)
		else $error("transmit empty during guard");
	timeout_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(idle_limit_q == 16'h0000) && !to_flag_q |=> !to_flag_q)
		else $error("time-out flag rose with zero limit");
	timeout_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst) (cmd_arm || cmd_reload) && !to_hit |=> !to_flag_q)
		else $error("time-out flag not cleared by command");
endmodule

// File: design/uptg_pkg.sv
/*
 * Shared constants for the parity, guard and idle time-out serial block:
 * register offsets, field positions, command bits, parity codes and reset values.
 * Assumes a 5-bit byte address on a plain strobe register port with 32-bit data.
 */
package uptg_pkg;
	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [4:0] UPTG_ADDR_CTRL   = 5'h00;
	localparam logic [4:0] UPTG_ADDR_MODE   = 5'h04;
	localparam logic [4:0] UPTG_ADDR_STATUS = 5'h08;
	localparam logic [4:0] UPTG_ADDR_RXHOLD = 5'h0c;
	localparam logic [4:0] UPTG_ADDR_TXHOLD = 5'h10;
	localparam logic [4:0] UPTG_ADDR_GUARD  = 5'h14;
	localparam logic [4:0] UPTG_ADDR_IDLE   = 5'h18;
	localparam logic [4:0] UPTG_ADDR_BAUD   = 5'h1c;
	// ****************************************************************
	// Control command bits
	// ****************************************************************
	localparam int UPTG_CMD_CLEAR_STATUS = 0;
	localparam int UPTG_CMD_SEND_ADDRESS = 1;
	localparam int UPTG_CMD_ARM_IDLE     = 2;
	localparam int UPTG_CMD_RELOAD_IDLE  = 3;
	// ****************************************************************
	// Status bit positions
	// ****************************************************************
	localparam int UPTG_ST_RX_READY = 0;
	localparam int UPTG_ST_TX_READY = 1;
	localparam int UPTG_ST_OVERRUN  = 5;
	localparam int UPTG_ST_PARITY   = 7;
	localparam int UPTG_ST_TIMEOUT  = 8;
	localparam int UPTG_ST_TX_EMPTY = 9;
	// ****************************************************************
	// Parity type codes
	// ****************************************************************
	localparam logic [2:0] UPTG_PAR_EVEN  = 3'h0;
	localparam logic [2:0] UPTG_PAR_ODD   = 3'h1;
	localparam logic [2:0] UPTG_PAR_SPACE = 3'h2;
	localparam logic [2:0] UPTG_PAR_MARK  = 3'h3;
	localparam logic [2:0] UPTG_PAR_NONE  = 3'h4;
	localparam logic [2:0] UPTG_PAR_NONE2 = 3'h5;
	localparam logic [2:0] UPTG_PAR_MD_A  = 3'h6;
	localparam logic [2:0] UPTG_PAR_MD_B  = 3'h7;
	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [2:0]  UPTG_MODE_RST  = 3'h4;
	localparam logic [15:0] UPTG_BAUD_RST  = 16'h001b;
	localparam logic [3:0]  UPTG_SAMP_LAST = 4'hf;
	localparam logic [3:0]  UPTG_SAMP_MID  = 4'h7;
	localparam logic [2:0]  UPTG_BIT_LAST  = 3'h7;
endpackage

// File: design/uptg_baud_div.sv
/*
 * Divider that makes the sixteen-times sample enable and the bit period enable.
 * Assumes the divisor is a register value that may change at any time.
 */
`timescale 1ns/1ps
module uptg_baud_div
	import uptg_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// Rate
	input  wire logic [15:0] divisor,
	// Enables
	output logic             samp_en,
	output logic             bit_en
);
	logic [15:0] cnt_q;
	logic [3:0]  phase_q;
	logic [15:0] last;

	// A divisor of zero behaves as one so the enables never stop.
	assign last    = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
	assign samp_en = (cnt_q >= last);
	assign bit_en  = samp_en && (phase_q == UPTG_SAMP_LAST);

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			cnt_q   <= 16'h0000;
			phase_q <= 4'h0;
		end
		else
		begin
			cnt_q <= samp_en ? 16'h0000 : cnt_q + 16'h0001;
			if (samp_en)
				phase_q <= phase_q + 4'h1;
		end
	end
endmodule

// File: design/uptg_sync.sv
/*
 * Three-stage input synchroniser with agreement filter for the serial line.
 * Assumes an idle-high line; the output follows once stages two and three agree.
 */
`timescale 1ns/1ps
module uptg_sync
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic nrst,
	// Line
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			s1_q      <= 1'b1;
			s2_q      <= 1'b1;
			s3_q      <= 1'b1;
			level_out <= 1'b1;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				level_out <= s3_q;
		end
	end
endmodule

// File: testbench/uptg_remote.sv
/*
 * Remote serial device: sends frames into the block and decodes frames out of it.
 * Assumes sixteen clocks per bit and an idle-high line.
 */
`timescale 1ns/1ps
module uptg_remote
(
	// Clock
	input  wire logic       clk_sys,
	// Lines
	output logic            tx_line,
	input  wire logic       rx_line,
	// Decoded frames
	input  wire logic       has_par,
	output logic            got_stb,
	output logic [7:0]      got_byte,
	output logic            got_par,
	output logic [7:0]      got_gap
);
	realtime t_high;
	int      k;
	initial
	begin
		tx_line = 1'b1;
		got_stb = 1'b0;
		t_high = 0;
	end
	task automatic send_char(input logic [7:0] b, input logic p_on, input logic p);
		int i;
		tx_line <= 1'b0;
		repeat (16) @(posedge clk_sys);
		for (i = 0; i < 8; i++)
		begin
			tx_line <= b[i];
			repeat (16) @(posedge clk_sys);
		end
		if (p_on)
		begin
			tx_line <= p;
			repeat (16) @(posedge clk_sys);
		end
		tx_line <= 1'b1;
		repeat (16) @(posedge clk_sys);
	endtask
	// ****************************************************************
	// Frame decoder; the gap is the high time before each start bit.
	// ****************************************************************
	always @(posedge rx_line) t_high = $realtime;
	always
	begin
		@(negedge rx_line);
		got_gap = 8'(int'(($realtime - t_high) / 20.0));
		repeat (8) @(posedge clk_sys);
		for (k = 0; k < 8; k++)
		begin
			repeat (16) @(posedge clk_sys);
			got_byte[k] = rx_line;
		end
		got_par = 1'b0;
		if (has_par)
		begin
			repeat (16) @(posedge clk_sys);
			got_par = rx_line;
		end
		repeat (16) @(posedge clk_sys);
		// Without parity a low stop sample shows up as a parity mismatch.
		if (!has_par)
			got_par = !rx_line;
		got_stb <= 1'b1;
		@(posedge clk_sys);
		got_stb <= 1'b0;
	end
endmodule

// File: testbench/uptg_top_test.sv
/*
 * Self-checking bench for the parity, guard and idle time-out serial block.
 * Assumes the remote device model and a baud divisor of one (bit = 16 clocks).
 */
`timescale 1ns/1ps
module uptg_top_test
	import uptg_pkg::*;
;
	logic        clk_sys, nrst, reg_wr, reg_rd, rxd_in, txd_out, timeout_event;
	logic [4:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_v, seed, m_e, m_m;
	logic        has_par, got_stb, got_par, rd_q, p;
	logic [7:0]  got_byte, got_gap, b;
	logic [2:0]  m;
	logic [16:0] m_t;
	logic [31:0] rd_exp[$];
	logic [31:0] rd_msk[$];
	logic [16:0] tx_q[$];
	int          n_fail, total_checks, n_to, cyc, mi, bad, g, i;
	uptg_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_in(rxd_in),
		.txd_out(txd_out), .timeout_event(timeout_event));
	uptg_remote partner_u (.clk_sys(clk_sys), .tx_line(rxd_in), .rx_line(txd_out), .has_par(has_par),
		.got_stb(got_stb), .got_byte(got_byte), .got_par(got_par), .got_gap(got_gap));
	initial clk_sys = 1'b0;
	always #10 clk_sys = ~clk_sys;
	task automatic close_out();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic par_of(input logic [2:0] md, input logic [7:0] d);
		case (md)
			UPTG_PAR_EVEN: return ^d;
			UPTG_PAR_ODD:  return ~^d;
			UPTG_PAR_MARK: return 1'b1;
			default:       return 1'b0;
		endcase
	endfunction
	// ****************************************************************
	// Register port master and waits
	// ****************************************************************
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] mk);
		rd_exp.push_back(e);
		rd_msk.push_back(mk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		rd_v = reg_rdata;
	endtask
	task automatic drain();
		int j;
		for (j = 0; j < 600 && tx_q.size() > 0; j++) @(posedge clk_sys);
		check({31'h0, tx_q.size() == 0}, 32'h1);
	endtask
	task automatic wait_to(input int lo, input int hi);
		int c;
		int n0;
		n0 = n_to;
		c = 0;
		while (n_to == n0 && c < hi)
		begin
			@(posedge clk_sys);
			c++;
		end
		check({31'h0, c >= lo && (c < hi || lo == hi)}, 32'h1);
	endtask
	// ****************************************************************
	// Result watcher and hang limit
	// ****************************************************************
	always @(posedge clk_sys)
	begin
		rd_q <= reg_rd;
		cyc++;
		if (timeout_event === 1'b1) n_to++;
		if (rd_q === 1'b1)
		begin
			m_m = rd_msk.pop_front();
			m_e = rd_exp.pop_front();
			if (m_m != 0) check(reg_rdata & m_m, m_e & m_m);
		end
		if (got_stb === 1'b1)
		begin
			m_t = tx_q.pop_front();
			check({23'h0, got_par, got_byte}, {23'h0, m_t[8:0]});
			if (m_t[16:9] != 0) check({24'h0, got_gap}, {24'h0, m_t[16:9]});
		end
		if (cyc == 40000)
		begin
			n_fail++;
			close_out();
		end
	end
	initial
	begin
		{nrst, reg_addr, reg_wdata, reg_wr, reg_rd, has_par, n_fail, total_checks, n_to, cyc} = '0;
		seed = 32'h644b7280;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		rd(UPTG_ADDR_STATUS, 32'h202, 32'h3a3);
		rd(UPTG_ADDR_MODE, {29'h0, UPTG_MODE_RST}, 32'h7);
		rd(UPTG_ADDR_BAUD, {16'h0, UPTG_BAUD_RST}, 32'hffff);
		rd(UPTG_ADDR_IDLE, 32'h0, 32'hffff);
		rd(5'h02, 32'h0, 32'hffffffff);
		wr(UPTG_ADDR_GUARD, 32'h1ff);
		rd(UPTG_ADDR_GUARD, 32'hff, 32'hffffffff);
		wr(UPTG_ADDR_GUARD, 32'h0);
		wr(UPTG_ADDR_BAUD, 32'h1);
		for (mi = 0; mi < 16; mi++)
		begin
			m = 3'(mi / 2);
			bad = mi % 2;
			seed = lfsr(seed);
			b = seed[7:0];
			p = (m != UPTG_PAR_NONE && m != UPTG_PAR_NONE2);
			wr(UPTG_ADDR_MODE, {29'h0, m});
			partner_u.send_char(b, p, par_of(m, b) ^ bad[0]);
			rd(UPTG_ADDR_STATUS, {24'h0, p & bad[0], 7'h1}, 32'ha1);
			rd(UPTG_ADDR_RXHOLD, {24'h0, b}, 32'hff);
			wr(UPTG_ADDR_CTRL, 32'h1);
			rd(UPTG_ADDR_STATUS, 32'h0, 32'ha1);
		end
		wr(UPTG_ADDR_MODE, 32'h4);
		seed = lfsr(seed);
		partner_u.send_char(seed[7:0], 1'b0, 1'b0);
		seed = lfsr(seed);
		partner_u.send_char(seed[7:0], 1'b0, 1'b0);
		rd(UPTG_ADDR_STATUS, 32'h21, 32'h21);
		rd(UPTG_ADDR_RXHOLD, {24'h0, seed[7:0]}, 32'hff);
		wr(UPTG_ADDR_CTRL, 32'h0);
		rd(UPTG_ADDR_STATUS, 32'h20, 32'h21);
		wr(UPTG_ADDR_CTRL, 32'h1);
		rd(UPTG_ADDR_STATUS, 32'h0, 32'h21);
		for (mi = 0; mi < 8; mi++)
		begin
			m = 3'(mi);
			has_par = (m != UPTG_PAR_NONE && m != UPTG_PAR_NONE2);
			seed = lfsr(seed);
			b = seed[7:0];
			p = (m == UPTG_PAR_MD_A) ? 1'b1 : par_of(m, b);
			wr(UPTG_ADDR_MODE, {29'h0, m});
			if (m == UPTG_PAR_MD_A) wr(UPTG_ADDR_CTRL, 32'h2);
			tx_q.push_back({8'h0, p & has_par, b});
			wr(UPTG_ADDR_TXHOLD, {24'h0, b});
			drain();
		end
		wr(UPTG_ADDR_MODE, 32'h4);
		has_par = 1'b0;
		for (g = 0; g < 4; g += 3)
		begin
			wr(UPTG_ADDR_GUARD, 32'(g));
			seed = lfsr(seed);
			// The first byte ends low so the high run starts at its stop bit.
			tx_q.push_back({8'h0, 2'b00, seed[6:0]});
			wr(UPTG_ADDR_TXHOLD, {25'h0, seed[6:0]});
			for (i = 0; i < 100; i++)
			begin
				rd(UPTG_ADDR_STATUS, 32'h0, 32'h0);
				if (rd_v[UPTG_ST_TX_READY] === 1'b1) break;
			end
			seed = lfsr(seed);
			tx_q.push_back({8'((g + 1) * 16), 1'b0, seed[7:0]});
			wr(UPTG_ADDR_TXHOLD, {24'h0, seed[7:0]});
			for (i = 0; i < 400 && tx_q.size() > 1; i++) @(posedge clk_sys);
			repeat (24) @(posedge clk_sys);
			rd(UPTG_ADDR_STATUS, (g == 0) ? 32'h2 : 32'h0, 32'h202);
			drain();
			repeat (72) @(posedge clk_sys);
			rd(UPTG_ADDR_STATUS, 32'h202, 32'h202);
		end
		wr(UPTG_ADDR_IDLE, 32'h4);
		for (i = 0; i < 2; i++)
		begin
			wr(UPTG_ADDR_CTRL, 32'h8);
			rd(UPTG_ADDR_STATUS, 32'h0, 32'h100);
			wait_to(36, 70);
			rd(UPTG_ADDR_STATUS, 32'h100, 32'h100);
		end
		wr(UPTG_ADDR_CTRL, 32'h4);
		rd(UPTG_ADDR_STATUS, 32'h0, 32'h100);
		wait_to(200, 200);
		partner_u.send_char(8'h5a, 1'b0, 1'b0);
		wait_to(20, 76);
		wr(UPTG_ADDR_IDLE, 32'h0);
		wr(UPTG_ADDR_CTRL, 32'h8);
		wait_to(200, 200);
		rd(UPTG_ADDR_STATUS, 32'h0, 32'h100);
		close_out();
	end
endmodule
